/* File: rtl/aesc_ctrl.sv */
// host controller that runs byte reads and writes on the asynchronous ecc memory pins
`timescale 1ns/1ps
module aesc_ctrl #(
    parameter bit FAST_GRADE = 1'b0,
    parameter int POWER_WAIT_CYC = aesc_pkg::POWER_STABLE_CYC,
    parameter int ADDR_W = 21,
    parameter int DATA_W = 8
) (
    input wire logic clk_in,
    input wire logic rst_in,
    // user request side
    input wire logic req_valid_in,
    input wire logic req_write_in,
    input wire logic [ADDR_W-1:0] req_addr_in,
    input wire logic [DATA_W-1:0] req_wdata_in,
    output logic req_ready_out,
    output logic rsp_valid_out,
    output logic [DATA_W-1:0] rsp_rdata_out,
    output logic rsp_err_out,
    // memory pins
    output logic select_primary_low_out,
    output logic select_secondary_high_out,
    output logic output_enable_low_out,
    output logic write_strobe_low_out,
    output logic [ADDR_W-1:0] mem_addr_out,
    input wire logic [DATA_W-1:0] mem_data_in,
    output logic [DATA_W-1:0] mem_data_out,
    output logic mem_data_oe_low_out,
    input wire logic mem_err_in
);
    // ------------------------------------------------------------------
    // cycle counts for the chosen speed grade
    // ------------------------------------------------------------------
    localparam int ACC_CYC = aesc_pkg::max2(aesc_pkg::max2(
        aesc_pkg::cycles_min(FAST_GRADE ? aesc_pkg::ADDR_ACCESS_NS10_FAST
                                        : aesc_pkg::ADDR_ACCESS_NS10_SLOW),
        aesc_pkg::cycles_min(FAST_GRADE ? aesc_pkg::SELECT_ACCESS_NS10_FAST
                                        : aesc_pkg::SELECT_ACCESS_NS10_SLOW)),
        aesc_pkg::cycles_min(FAST_GRADE ? aesc_pkg::OE_ACCESS_NS10_FAST
                                        : aesc_pkg::OE_ACCESS_NS10_SLOW));
    localparam int READ_CYC = ACC_CYC + aesc_pkg::SYNC_STAGES;
    localparam int REL_CYC = aesc_pkg::cycles_min(FAST_GRADE
        ? aesc_pkg::WRITE_RELEASE_NS10_FAST : aesc_pkg::WRITE_RELEASE_NS10_SLOW);
    localparam int DESEL_CYC = aesc_pkg::cycles_min(FAST_GRADE
        ? aesc_pkg::DESELECT_RELEASE_NS10_FAST : aesc_pkg::DESELECT_RELEASE_NS10_SLOW);
    localparam int SETUP_CYC = aesc_pkg::cycles_min(FAST_GRADE
        ? aesc_pkg::DATA_SETUP_NS10_FAST : aesc_pkg::DATA_SETUP_NS10_SLOW);
    localparam int PULSE_CYC = aesc_pkg::max2(aesc_pkg::cycles_min(FAST_GRADE
        ? aesc_pkg::WRITE_PULSE_NS10_FAST : aesc_pkg::WRITE_PULSE_NS10_SLOW),
        aesc_pkg::cycles_min(FAST_GRADE
        ? aesc_pkg::SELECT_TO_END_NS10_FAST : aesc_pkg::SELECT_TO_END_NS10_SLOW));
    // setup and width
    // data phase long enough for setup and for the strobe width left after the release phase
    localparam int DATA_CYC = aesc_pkg::max2(SETUP_CYC, PULSE_CYC - REL_CYC);
    localparam int TW = aesc_pkg::TIMER_W;

    typedef enum logic [2:0] {
        AESC_INIT, AESC_POWER, AESC_IDLE, AESC_READ, AESC_WR_REL, AESC_WR_DATA,
        AESC_WR_HOLD, AESC_GAP
    } aesc_state_t;

    aesc_state_t state;
    logic tmr_load;
    logic [TW-1:0] tmr_value;
    logic tmr_done;
    logic [DATA_W-1:0] data_meta;
    logic [DATA_W-1:0] data_sync;
    logic err_meta;
    logic err_sync;
    logic selected;

    aesc_timer #(.WIDTH(TW)) u_timer (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .load_in(tmr_load),
        .value_in(tmr_value),
        .done_out(tmr_done)
    );

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            data_meta <= aesc_pkg::DATA_RESET;
            data_sync <= aesc_pkg::DATA_RESET;
            err_meta <= 1'b0;
            err_sync <= 1'b0;
        end else begin
            data_meta <= mem_data_in;
            data_sync <= data_meta;
            err_meta <= mem_err_in;
            err_sync <= err_meta;
        end
    end

    // ------------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------------
    assign req_ready_out = (state == AESC_IDLE);

    always_comb begin
        tmr_load = 1'b0;
        tmr_value = '0;
        case (state)
            AESC_INIT: begin
                tmr_load = 1'b1;
                tmr_value = TW'(POWER_WAIT_CYC);
            end
            AESC_IDLE: begin
                tmr_load = req_valid_in;
                tmr_value = req_write_in ? TW'(REL_CYC) : TW'(READ_CYC);
            end
            AESC_READ: begin
                tmr_load = tmr_done;
                tmr_value = TW'(DESEL_CYC);
            end
            AESC_WR_REL: begin
                tmr_load = tmr_done;
                tmr_value = TW'(DATA_CYC);
            end
            AESC_WR_HOLD: begin
                tmr_load = 1'b1;
                tmr_value = TW'(DESEL_CYC);
            end
            default: begin
                tmr_load = 1'b0;
                tmr_value = '0;
            end
        endcase
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state <= AESC_INIT;
        end else begin
            case (state)
                AESC_INIT: state <= AESC_POWER;
                AESC_POWER: if (tmr_done) state <= AESC_IDLE;
                AESC_IDLE: begin
                    if (req_valid_in) begin
                        state <= req_write_in ? AESC_WR_REL : AESC_READ;
                    end
                end
                AESC_READ: if (tmr_done) state <= AESC_GAP;
                AESC_WR_REL: if (tmr_done) state <= AESC_WR_DATA;
                AESC_WR_DATA: if (tmr_done) state <= AESC_WR_HOLD;
                AESC_WR_HOLD: state <= AESC_GAP;
                // gap lets the memory float the bus before anyone drives it again
                AESC_GAP: if (tmr_done) state <= AESC_IDLE;
                default: state <= AESC_INIT;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // memory control pins
    // ------------------------------------------------------------------
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            selected <= 1'b0;
            output_enable_low_out <= 1'b1;
            write_strobe_low_out <= 1'b1;
            mem_addr_out <= '0;
        end else if (state == AESC_IDLE && req_valid_in) begin
            selected <= 1'b1;
            output_enable_low_out <= req_write_in;
            write_strobe_low_out <= !req_write_in;
            mem_addr_out <= req_addr_in;
        end else if ((state == AESC_READ || state == AESC_WR_DATA) && tmr_done) begin
            // select and strobe rise together after the full pulse
            selected <= 1'b0;
            output_enable_low_out <= 1'b1;
            write_strobe_low_out <= 1'b1;
        end
    end

    assign select_primary_low_out = !selected;
    assign select_secondary_high_out = selected;

    // ------------------------------------------------------------------
    // write data drive
    // ------------------------------------------------------------------
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            mem_data_out <= aesc_pkg::DATA_RESET;
            mem_data_oe_low_out <= 1'b1;
        end else if (state == AESC_IDLE && req_valid_in && req_write_in) begin
            mem_data_out <= req_wdata_in;
        end else if (state == AESC_WR_REL && tmr_done) begin
            // drive only after the release delay has run
            mem_data_oe_low_out <= 1'b0;
        end else if (state == AESC_WR_HOLD) begin
            mem_data_oe_low_out <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // read answer
    // ------------------------------------------------------------------
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            rsp_valid_out <= 1'b0;
            rsp_rdata_out <= aesc_pkg::DATA_RESET;
            rsp_err_out <= 1'b0;
        end else begin
            rsp_valid_out <= (state == AESC_READ) && tmr_done;
            if (state == AESC_READ && tmr_done) begin
                // flag sampled with the data it belongs to
                rsp_rdata_out <= data_sync;
                rsp_err_out <= err_sync;
            end
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    int unsigned we_cnt;
    int unsigned drv_cnt;
    int unsigned pwr_cnt;
    int unsigned oe_cnt;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            we_cnt <= 0;
            drv_cnt <= 0;
            pwr_cnt <= 0;
            oe_cnt <= 0;
        end else begin
            we_cnt <= write_strobe_low_out ? 0 : we_cnt + 1;
            drv_cnt <= mem_data_oe_low_out ? 0 : drv_cnt + 1;
            oe_cnt <= output_enable_low_out ? 0 : oe_cnt + 1;
            if (pwr_cnt < POWER_WAIT_CYC) pwr_cnt <= pwr_cnt + 1;
        end
    end

    power_wait_a: assert property (@(posedge clk_in) disable iff (rst_in)
        selected |-> pwr_cnt >= POWER_WAIT_CYC) else $error("access before power wait");
    select_pair_a: assert property (@(posedge clk_in) disable iff (rst_in)
        select_primary_low_out == !select_secondary_high_out) else $error("select split");
    write_begin_a: assert property (@(posedge clk_in) disable iff (rst_in)
        !write_strobe_low_out |-> selected) else $error("strobe without select");
    // data driven only late in a write with outputs disabled
    no_contention_a: assert property (@(posedge clk_in) disable iff (rst_in)
        !mem_data_oe_low_out |-> output_enable_low_out && we_cnt >= REL_CYC)
        else $error("data driven too early");
    // data stands setup time before strobe rises
    data_setup_a: assert property (@(posedge clk_in) disable iff (rst_in)
        $rose(write_strobe_low_out) |-> $past(drv_cnt) >= SETUP_CYC)
        else $error("data setup short");
    // strobe width covers release and setup
    pulse_width_a: assert property (@(posedge clk_in) disable iff (rst_in)
        $rose(write_strobe_low_out) |-> $past(we_cnt) >= REL_CYC + SETUP_CYC)
        else $error("strobe too short");
    // select low long enough before write end
    select_hold_a: assert property (@(posedge clk_in) disable iff (rst_in)
        $rose(write_strobe_low_out) |-> $past(we_cnt) >= PULSE_CYC && $fell(selected))
        else $error("select hold short");
    // read answer only after access plus sync time
    read_sample_a: assert property (@(posedge clk_in) disable iff (rst_in)
        rsp_valid_out |-> $past(oe_cnt) >= READ_CYC) else $error("read sampled early");
    // data released the cycle after the strobe rises
    data_release_a: assert property (@(posedge clk_in) disable iff (rst_in)
        $rose(write_strobe_low_out) |=> mem_data_oe_low_out) else $error("data not released");

    read_cov_c: cover property (@(posedge clk_in) disable iff (rst_in) rsp_valid_out);
    write_cov_c: cover property (@(posedge clk_in) disable iff (rst_in)
        $rose(write_strobe_low_out));
    err_cov_c: cover property (@(posedge clk_in) disable iff (rst_in)
        rsp_valid_out && rsp_err_out);
    back_cov_c: cover property (@(posedge clk_in) disable iff (rst_in)
        $rose(write_strobe_low_out) ##[1:10] rsp_valid_out);
endmodule

/* File: rtl/aesc_timer.sv */
// down counter that flags when a loaded cycle count has run out
`timescale 1ns/1ps
module aesc_timer #(
    parameter int WIDTH = 16
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic load_in,
    input wire logic [WIDTH-1:0] value_in,
    output logic done_out
);
    logic [WIDTH-1:0] count;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            count <= '0;
        end else if (load_in) begin
            count <= value_in;
        end else if (count != '0) begin
            count <= count - 1'b1;
        end
    end

    // done reads the count alone: callers load done back in, so gating it by load would loop
    assign done_out = (count == '0);
endmodule

/* File: shared/aesc_pkg.sv */
// constants and helpers for the asynchronous ecc static memory host controller
//
// Notes on behaviour
// - a write starts only while write strobe and combined select are both low.
// - host holds write data stable for the setup time before the ending edge.
// - host never drives data lines until the memory has released them.
// - strobe low time covers release delay plus data setup time.
// - host waits the power stable interval before the first access.
package aesc_pkg;
    // ------------------------------------------------------------------
    // clock and timing figures, in tenths of a nanosecond
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS10 = 80;
    localparam int ADDR_ACCESS_NS10_FAST = 100;
    localparam int ADDR_ACCESS_NS10_SLOW = 150;
    localparam int SELECT_ACCESS_NS10_FAST = 100;
    localparam int SELECT_ACCESS_NS10_SLOW = 150;
    localparam int OE_ACCESS_NS10_FAST = 50;
    localparam int OE_ACCESS_NS10_SLOW = 80;
    localparam int WRITE_RELEASE_NS10_FAST = 50;
    localparam int WRITE_RELEASE_NS10_SLOW = 80;
    localparam int DESELECT_RELEASE_NS10_FAST = 50;
    localparam int DESELECT_RELEASE_NS10_SLOW = 80;
    localparam int DATA_SETUP_NS10_FAST = 50;
    localparam int DATA_SETUP_NS10_SLOW = 80;
    localparam int WRITE_PULSE_NS10_FAST = 70;
    localparam int WRITE_PULSE_NS10_SLOW = 120;
    localparam int SELECT_TO_END_NS10_FAST = 70;
    localparam int SELECT_TO_END_NS10_SLOW = 120;
    // power stable wait in microseconds
    localparam int POWER_STABLE_US = 100;
    localparam int POWER_STABLE_CYC = (POWER_STABLE_US * 10000 + CLK_PERIOD_NS10 - 1)
        / CLK_PERIOD_NS10;
    // input synchroniser depth on data and error pins
    localparam int SYNC_STAGES = 2;
    localparam int TIMER_W = 16;
    localparam logic [7:0] DATA_RESET = 8'h00;

    // least time rounds up to whole cycles, never below one
    function automatic int cycles_min(input int ns10);
        int c;
        c = (ns10 + CLK_PERIOD_NS10 - 1) / CLK_PERIOD_NS10;
        return (c < 1) ? 1 : c;
    endfunction

    function automatic int max2(input int a, input int b);
        return (a > b) ? a : b;
    endfunction
endpackage

/* File: tb/aesc_mem_model.sv */
// behavioural model of the asynchronous ecc byte memory on the far side of the controller
`timescale 1ns/1ps
module aesc_mem_model #(
    parameter int ACC_NS = 15,
    parameter int HOLD_NS = 3,
    parameter int SETUP_NS = 8,
    parameter int SCE_NS = 12,
    parameter int PD_NS = 15
) (
    input wire logic select_primary_low_in,
    input wire logic select_secondary_high_in,
    input wire logic output_enable_low_in,
    input wire logic write_strobe_low_in,
    input wire logic [20:0] addr_in,
    input wire logic [7:0] bus_in,
    input wire logic [20:0] err_addr_in,
    output logic [7:0] dq_out,
    output logic drive_out,
    output logic err_out,
    output int viol_out
);
    logic sel;
    logic rd;
    logic wr;
    logic valid;
    logic standby;
    int tok;
    realtime t_bus;
    realtime t_wr;
    logic [7:0] mem [logic [20:0]];

    assign sel = !select_primary_low_in && select_secondary_high_in;
    // read path only when selected, enabled and not writing
    assign rd = sel && !output_enable_low_in && write_strobe_low_in;
    assign wr = sel && !write_strobe_low_in;
    assign drive_out = rd && valid;

    initial begin
        tok = 0;
        valid = 1'b0;
        dq_out = 8'h00;
        err_out = 1'b0;
        viol_out = 0;
        standby = 1'b1;
        t_bus = 0;
        t_wr = 0;
    end

    // ------------------------------------------------------------------
    // read side: old data held briefly, then garbage, then the new word
    // ------------------------------------------------------------------
    // access
    always @(sel, output_enable_low_in, write_strobe_low_in, addr_in) begin
        tok = tok + 1;
        fork
            begin
                automatic int t = tok;
                #(HOLD_NS);
                // inverted pattern so a stale value never passes for valid data
                if (t == tok) begin
                    valid = 1'b0;
                    dq_out = ~dq_out;
                    err_out = ~err_out;
                end
                #(ACC_NS - HOLD_NS);
                if (t == tok && rd) begin
                    dq_out = mem.exists(addr_in) ? mem[addr_in] : 8'h00;
                    err_out = (addr_in == err_addr_in);
                    valid = 1'b1;
                end
            end
        join_none
    end

    // ------------------------------------------------------------------
    // write side: stored on the edge that ends the overlap
    // ------------------------------------------------------------------
    always @(bus_in) t_bus = $realtime;
    // write window opens with the overlap
    always @(posedge wr) t_wr = $realtime;
    // store at write end, setup and overlap minima counted
    always @(negedge wr) begin
        if ($realtime - t_bus < SETUP_NS || $realtime - t_wr < SCE_NS) begin
            viol_out = viol_out + 1;
        end
        mem[addr_in] = bus_in;
    end

    // standby after deselect, wakes at once
    always @(sel) begin
        if (sel) begin
            standby = 1'b0;
        end else begin
            fork
                #(PD_NS) if (!sel) standby = 1'b1;
            join_none
        end
    end
endmodule

/* File: tb/testbench.sv */
// self-checking bench for the ecc memory host controller against a memory model
`timescale 1ns/1ps
module testbench;
    localparam int POWER = 20;
    logic clk_in, rst_in, req_valid_in, req_write_in, req_ready_out, rsp_valid_out;
    logic rsp_err_out, sel_low, sel_high, oe_low, we_low, data_oe_low, drive, err;
    logic [20:0] req_addr_in, mem_addr_out, err_addr;
    logic [7:0] req_wdata_in, rsp_rdata_out, mem_data_out, dq, bus;
    int viol, n_errors, checks, cycles, clash, sel_bad;
    logic [20:0] addrs [4] = '{21'h00_0000, 21'h1f_ffff, 21'h00_0001, 21'h10_0000};
    logic [7:0] datas [4] = '{8'h5a, 8'ha5, 8'h00, 8'hff};

    // host wins the bus while it drives, otherwise whatever the memory shows
    assign bus = (data_oe_low == 1'b0) ? mem_data_out : dq;

    aesc_ctrl #(.FAST_GRADE(1'b0), .POWER_WAIT_CYC(POWER)) u_dut (
        .clk_in(clk_in), .rst_in(rst_in), .req_valid_in(req_valid_in),
        .req_write_in(req_write_in), .req_addr_in(req_addr_in), .req_wdata_in(req_wdata_in),
        .req_ready_out(req_ready_out), .rsp_valid_out(rsp_valid_out),
        .rsp_rdata_out(rsp_rdata_out), .rsp_err_out(rsp_err_out),
        .select_primary_low_out(sel_low), .select_secondary_high_out(sel_high),
        .output_enable_low_out(oe_low), .write_strobe_low_out(we_low),
        .mem_addr_out(mem_addr_out), .mem_data_in(bus), .mem_data_out(mem_data_out),
        .mem_data_oe_low_out(data_oe_low), .mem_err_in(err));

    aesc_mem_model u_mem (
        .select_primary_low_in(sel_low), .select_secondary_high_in(sel_high),
        .output_enable_low_in(oe_low), .write_strobe_low_in(we_low),
        .addr_in(mem_addr_out), .bus_in(bus), .err_addr_in(err_addr),
        .dq_out(dq), .drive_out(drive), .err_out(err), .viol_out(viol));

    always #4 clk_in = ~clk_in;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR at %0t: %s seen %0h expected %0h", $time, msg, seen, exp);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // drifting flags counted at each falling edge and judged at the end
    always @(negedge clk_in) begin
        if (data_oe_low == 1'b0 && drive) clash++;
        if (sel_low === sel_high) sel_bad++;
    end

    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 4000) begin
            n_errors++;
            stop_test();
        end
    end

    // called at a falling edge; returns at the falling edge after the taking edge
    task automatic do_req(input logic w, input logic [20:0] a, input logic [7:0] d);
        while (req_ready_out !== 1'b1) @(negedge clk_in);
        req_valid_in = 1'b1;
        req_write_in = w;
        req_addr_in = a;
        req_wdata_in = d;
        @(negedge clk_in);
        req_valid_in = 1'b0;
    endtask

    task automatic do_read(input logic [20:0] a, input logic [7:0] d, input logic e);
        int n;
        n = 0;
        do_req(1'b0, a, 8'h00);
        while (rsp_valid_out !== 1'b1 && n < 20) begin
            @(negedge clk_in);
            n++;
        end
        check(n < 20, 1, "no read answer");
        check(rsp_rdata_out, d, "read data");
        check(rsp_err_out, e, "error flag");
    endtask

    // reset held, idle pins checked, then the power wait counted
    task automatic t_power_up();
        int n;
        n = 0;
        rst_in = 1'b1;
        repeat (8) @(negedge clk_in);
        check({sel_low, sel_high, we_low, oe_low, data_oe_low}, 5'h17, "idle pins");
        rst_in = 1'b0;
        while (req_ready_out !== 1'b1 && n < 100) begin
            @(negedge clk_in);
            n++;
        end
        check(n >= POWER && n < 100, 1, "power wait");
    endtask

    // back-to-back writes across the address range, read back in reverse
    task automatic t_write_read();
        for (int i = 0; i < 4; i++) do_req(1'b1, addrs[i], datas[i]);
        for (int i = 3; i >= 0; i--) do_read(addrs[i], datas[i], 1'b0);
        do_req(1'b1, addrs[2], 8'h3c);
        do_read(addrs[2], 8'h3c, 1'b0);
    endtask

    task automatic t_err_flag();
        err_addr = addrs[1];
        do_read(addrs[1], datas[1], 1'b1);
        do_read(addrs[0], datas[0], 1'b0);
        do_read(addrs[1], datas[1], 1'b1);
    endtask

    // reset in mid-read: pins fall idle, power wait repeats, contents survive
    task automatic t_reset_mid();
        do_req(1'b0, addrs[3], 8'h00);
        @(negedge clk_in);
        rst_in = 1'b1;
        @(negedge clk_in);
        check({sel_low, sel_high, we_low, oe_low}, 4'hb, "pins during reset");
        t_power_up();
        do_read(addrs[3], datas[3], 1'b0);
    endtask

    initial begin
        clk_in = 1'b0;
        rst_in = 1'b1;
        req_valid_in = 1'b0;
        req_write_in = 1'b0;
        req_addr_in = 21'h00_0000;
        req_wdata_in = 8'h00;
        err_addr = 21'h0a_5555;
        n_errors = 0;
        checks = 0;
        cycles = 0;
        clash = 0;
        sel_bad = 0;
        t_power_up();
        t_write_read();
        t_err_flag();
        t_reset_mid();
        check(viol, 0, "write setup or overlap short");
        check(clash, 0, "bus contention");
        check(sel_bad, 0, "selects not complementary");
        stop_test();
    end
endmodule
